// ---- src/dsp_parallel_port.sv ----
`include "pio_consts.svh"
module dsp_parallel_port
  import pio_pkg::*;
(
  input  wire logic                 clk_sys,            // crystal-rate clock
  input  wire logic                 srst,               // sync reset, high
  input  wire logic                 slaveMode,          // mode pin, 1 = slave
  input  wire mem_req_t             memReq,             // access request
  input  wire mode_cfg_t            modeCfg,            // status settings
  input  wire logic [`GP_W-1:0]     gpoWrData,          // general output data
  input  wire logic                 gpoWrEn,            // general output write
  input  wire logic [`MDATA_W-1:0]  hostTxWord,         // word for host to read
  input  wire logic                 hostTxLoad,         // load word for host
  input  wire logic                 hostRxTake,         // core took host word
  output logic                      memBusy,            // access in progress
  output logic [`MDATA_W-1:0]       memRdData,          // read result
  output logic                      memRdValid,         // read result pulse
  output logic [`MDATA_W-1:0]       hostRxWord,         // word from host
  output logic                      hostRxValid,        // host word ready
  output logic [`GP_W-1:0]          gpInRead,           // general input level
  output logic                      sysClkOut,          // half-rate clock out
  input  wire logic                 host_cs_n,          // chip select
  input  wire logic                 host_write_strobe_n,// host write strobe
  input  wire logic                 host_read_strobe_n, // host read strobe
  input  wire logic [`HDATA_W-1:0]  host_data_bus_i,    // host bus in
  output logic [`HDATA_W-1:0]       host_data_bus_o,    // host bus out
  output logic                      host_data_bus_oe,   // host bus drive
  output logic                      host_transfer_request, // host request
  output logic [`ADDR_W-1:0]        memory_address_out, // memory address
  output logic                      speed_area_select,  // top address bit
  output logic                      mem_wr_n,           // memory write
  output logic                      mem_rd_n,           // memory read
  input  wire logic [`MDATA_W-1:0]  master_memory_data_i,  // master bus in
  output logic [`MDATA_W-1:0]       master_memory_data_o,  // master bus out
  output logic                      master_memory_data_oe, // master bus drive
  input  wire logic [`SDATA_W-1:0]  slave_memory_data_i,   // slave bus in
  output logic [`SDATA_W-1:0]       slave_memory_data_o,   // slave bus out
  output logic                      slave_memory_data_oe,  // slave bus drive
  input  wire logic [`GP_W-1:0]     gp_input_pins,      // general inputs
  output logic [`GP_W-1:0]          gp_output_pins      // general outputs
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0]             csSync_ff, wrSync_ff, rdSync_ff, modeSync_ff;
  logic [`GP_W-1:0]       gpS1_ff, gpS2_ff, gpS3_ff;
  logic [`HDATA_W-1:0]    hdS1_ff, hdS2_ff;
  logic [`SDATA_W-1:0]    sdS1_ff;
  logic [`MDATA_W-1:0]    mdS1_ff;
  logic                   csLo, wrLo, rdLo, wrLoPrev_ff, rdLoPrev_ff;
  logic                   isSlave;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      csSync_ff   <= 3'h7;
      wrSync_ff   <= 3'h7;
      rdSync_ff   <= 3'h7;
      modeSync_ff <= 3'h0;
      gpS1_ff     <= `GPO_RST;
      gpS2_ff     <= `GPO_RST;
      gpS3_ff     <= `GPO_RST;
      wrLoPrev_ff <= 1'b0;
      rdLoPrev_ff <= 1'b0;
    end else begin
      csSync_ff   <= {csSync_ff[1:0], host_cs_n};
      wrSync_ff   <= {wrSync_ff[1:0], host_write_strobe_n};
      rdSync_ff   <= {rdSync_ff[1:0], host_read_strobe_n};
      modeSync_ff <= {modeSync_ff[1:0], slaveMode};
      gpS1_ff     <= gp_input_pins;
      gpS2_ff     <= gpS1_ff;
      gpS3_ff     <= gpS2_ff;
      wrLoPrev_ff <= wrLo;
      rdLoPrev_ff <= rdLo;
    end
  end

  always_ff @(posedge clk_sys) begin
    hdS1_ff <= host_data_bus_i;
    hdS2_ff <= hdS1_ff;
    sdS1_ff <= slave_memory_data_i;
    mdS1_ff <= master_memory_data_i;
  end

  // a level counts once stages two and three agree
  logic csLo_ff, wrLo_ff, rdLo_ff, slave_ff;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      csLo_ff  <= 1'b0;
      wrLo_ff  <= 1'b0;
      rdLo_ff  <= 1'b0;
      slave_ff <= 1'b0;
    end else begin
      if (csSync_ff[1] == csSync_ff[2]) csLo_ff <= ~csSync_ff[2];
      if (wrSync_ff[1] == wrSync_ff[2]) wrLo_ff <= ~wrSync_ff[2];
      if (rdSync_ff[1] == rdSync_ff[2]) rdLo_ff <= ~rdSync_ff[2];
      if (modeSync_ff[1] == modeSync_ff[2]) slave_ff <= modeSync_ff[2];
    end
  end
  assign isSlave = slave_ff;
  assign csLo    = csLo_ff;
  assign wrLo    = wrLo_ff & csLo_ff;
  assign rdLo    = rdLo_ff & csLo_ff;

  // ************************************************************
  // system clock divider
  // ************************************************************
  logic sysClk_ff, nxt_sysClk;
  assign nxt_sysClk = ~sysClk_ff;
  always_ff @(posedge clk_sys) begin
    if (srst) sysClk_ff <= 1'b0;
    else      sysClk_ff <= nxt_sysClk;
  end
  logic sysEn;
  assign sysEn = sysClk_ff;

  // ************************************************************
  // host port
  // ************************************************************
  logic [`MDATA_W-1:0] hostBuf_ff, nxt_hostBuf;
  logic                halfIdx_ff, nxt_halfIdx;
  logic                rxFull_ff, nxt_rxFull;
  logic                txFull_ff, nxt_txFull;
  logic                hOe_ff, nxt_hOe;
  logic [`HDATA_W-1:0] hOut_ff, nxt_hOut;
  logic                rqm_ff, nxt_rqm;
  logic                wrDone, rdDone;

  assign wrDone = wrLoPrev_ff & ~wrLo;
  assign rdDone = rdLoPrev_ff & ~rdLo;

  always_comb begin
    nxt_hostBuf = hostBuf_ff;
    nxt_halfIdx = halfIdx_ff;
    nxt_rxFull  = rxFull_ff & ~hostRxTake;
    nxt_txFull  = txFull_ff;
    if (hostTxLoad) begin
      nxt_hostBuf = hostTxWord;
      nxt_txFull  = 1'b1;
      nxt_halfIdx = 1'b0;
    end else if (isSlave && wrDone) begin
      if (halfIdx_ff) nxt_hostBuf[31:16] = hdS2_ff;
      else            nxt_hostBuf[15:0]  = hdS2_ff;
      if (!modeCfg.wide32 || halfIdx_ff) begin
        nxt_rxFull  = 1'b1;
        nxt_halfIdx = 1'b0;
      end else begin
        nxt_halfIdx = 1'b1;
      end
    end else if (isSlave && rdDone) begin
      if (!modeCfg.wide32 || halfIdx_ff) begin
        nxt_txFull  = 1'b0;
        nxt_halfIdx = 1'b0;
      end else begin
        nxt_halfIdx = 1'b1;
      end
    end
    nxt_hOe  = isSlave & rdLo;
    nxt_hOut = halfIdx_ff ? hostBuf_ff[31:16] : hostBuf_ff[15:0];
    nxt_rqm  = isSlave & (nxt_txFull | ~nxt_rxFull);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hostBuf_ff <= `BUF_RST;
      halfIdx_ff <= 1'b0;
      rxFull_ff  <= 1'b0;
      txFull_ff  <= 1'b0;
      hOe_ff     <= 1'b0;
      hOut_ff    <= '0;
      rqm_ff     <= 1'b0;
    end else begin
      hostBuf_ff <= nxt_hostBuf;
      halfIdx_ff <= nxt_halfIdx;
      rxFull_ff  <= nxt_rxFull;
      txFull_ff  <= nxt_txFull;
      hOe_ff     <= nxt_hOe;
      hOut_ff    <= nxt_hOut;
      rqm_ff     <= nxt_rqm;
    end
  end

  // ************************************************************
  // external memory sequencer
  // ************************************************************
  mem_state_t          st_ff, nxt_st;
  logic [`AREG_W-1:0]  addrReg_ff, nxt_addrReg;
  logic [`MDATA_W-1:0] dataBuf_ff, nxt_dataBuf;
  logic [2:0]          bytesLeft_ff, nxt_bytesLeft;
  logic [1:0]          byteIdx_ff, nxt_byteIdx;
  logic                fetch_ff, nxt_fetch;
  logic                rdV_ff, nxt_rdV, busy_ff, nxt_busy;
  logic [2:0]          reqBytes;

  assign reqBytes = (memReq.byteCnt == 3'h0) ? {1'b0, modeCfg.byteSel} + 3'h1
                                             : memReq.byteCnt;

  always_comb begin
    nxt_st        = st_ff;
    nxt_addrReg   = addrReg_ff;
    nxt_dataBuf   = dataBuf_ff;
    nxt_bytesLeft = bytesLeft_ff;
    nxt_byteIdx   = byteIdx_ff;
    nxt_fetch     = fetch_ff;
    nxt_rdV       = 1'b0;
    if (sysEn) begin
      unique case (st_ff)
        MS_IDLE: begin
          if (memReq.valid) begin
            nxt_addrReg   = memReq.addr;
            nxt_fetch     = memReq.isFetch & ~isSlave;
            nxt_dataBuf   = memReq.wdata;
            nxt_bytesLeft = isSlave ? reqBytes : 3'h1;
            nxt_byteIdx   = 2'h0;
            nxt_st        = memReq.write ? MS_WRLO : MS_RDLO;
          end
        end
        MS_RDLO: nxt_st = MS_RDHI;
        MS_RDHI: begin
          if (isSlave) nxt_dataBuf[byteIdx_ff*8 +: 8] = sdS1_ff;
          else         nxt_dataBuf = mdS1_ff;
          nxt_bytesLeft = bytesLeft_ff - 3'h1;
          nxt_byteIdx   = byteIdx_ff + 2'h1;
          if (bytesLeft_ff == 3'h1) begin
            nxt_st  = MS_IDLE;
            nxt_rdV = 1'b1;
          end else begin
            nxt_st = MS_RDLO;
          end
          nxt_addrReg = addrReg_ff + 13'h1;
        end
        MS_WRLO: nxt_st = MS_WRHI;
        MS_WRHI: begin
          nxt_bytesLeft = bytesLeft_ff - 3'h1;
          nxt_byteIdx   = byteIdx_ff + 2'h1;
          nxt_st        = (bytesLeft_ff == 3'h1) ? MS_IDLE : MS_WRLO;
          nxt_addrReg   = addrReg_ff + 13'h1;
        end
        default: nxt_st = MS_IDLE;
      endcase
    end
    nxt_busy = (nxt_st != MS_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff        <= MS_IDLE;
      addrReg_ff   <= '0;
      dataBuf_ff   <= `BUF_RST;
      bytesLeft_ff <= 3'h0;
      byteIdx_ff   <= 2'h0;
      fetch_ff     <= 1'b0;
      rdV_ff       <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      addrReg_ff   <= nxt_addrReg;
      dataBuf_ff   <= nxt_dataBuf;
      bytesLeft_ff <= nxt_bytesLeft;
      byteIdx_ff   <= nxt_byteIdx;
      fetch_ff     <= nxt_fetch;
      rdV_ff       <= nxt_rdV;
      busy_ff      <= nxt_busy;
    end
  end

  // ************************************************************
  // registered pins
  // ************************************************************
  logic inWr;
  assign inWr = (nxt_st == MS_WRLO) | (nxt_st == MS_WRHI);

  logic [`GP_W-1:0] gpo_ff;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      memory_address_out    <= `ADDR_RST;
      speed_area_select     <= 1'b0;
      mem_wr_n              <= 1'b1;
      mem_rd_n              <= 1'b1;
      master_memory_data_o  <= '0;
      master_memory_data_oe <= 1'b0;
      slave_memory_data_o   <= '0;
      slave_memory_data_oe  <= 1'b0;
      gpo_ff                <= `GPO_RST;
      gpInRead              <= `GPO_RST;
    end else begin
      memory_address_out    <= nxt_addrReg[`ADDR_W-1:0];
      speed_area_select     <= nxt_fetch ? 1'b0 : nxt_addrReg[`AREG_TOP_BIT];
      mem_wr_n              <= ~(nxt_st == MS_WRHI);
      mem_rd_n              <= ~(nxt_st == MS_RDHI);
      master_memory_data_o  <= nxt_dataBuf;
      master_memory_data_oe <= inWr & ~isSlave;
      slave_memory_data_o   <= nxt_dataBuf[nxt_byteIdx*8 +: 8];
      slave_memory_data_oe  <= inWr & isSlave;
      if (gpoWrEn) gpo_ff <= gpoWrData;
      gpInRead              <= isSlave ? gpS3_ff : `GPO_RST;
    end
  end

  assign memBusy               = busy_ff;
  assign memRdData             = dataBuf_ff;
  assign memRdValid            = rdV_ff;
  assign hostRxWord            = hostBuf_ff;
  assign hostRxValid           = rxFull_ff;
  assign host_data_bus_o       = hOut_ff;
  assign host_data_bus_oe      = hOe_ff;
  assign host_transfer_request = rqm_ff;
  assign gp_output_pins        = gpo_ff;
  assign sysClkOut             = sysClk_ff;
endmodule : dsp_parallel_port

// ---- src/pio_consts.svh ----
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
// ************************************************************
// widths
// ************************************************************
`define ADDR_W        12
`define AREG_W        13
`define MDATA_W       32
`define HDATA_W       16
`define SDATA_W       8
`define GP_W          2
// ************************************************************
// field positions and reset values
// ************************************************************
`define AREG_TOP_BIT  12
`define PC_TOP_BIT    12
`define CLKDIV_W      1
`define GPO_RST       2'h0
`define BUF_RST       32'h0000_0000
`define ADDR_RST      12'h000
`endif

// ---- src/pio_pkg.sv ----
`include "pio_consts.svh"
package pio_pkg;
  typedef enum logic [2:0] {
    MS_IDLE  = 3'b000,
    MS_RDLO  = 3'b001,
    MS_RDHI  = 3'b010,
    MS_WRLO  = 3'b011,
    MS_WRHI  = 3'b100
  } mem_state_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic                  isFetch;
    logic [`AREG_W-1:0]    addr;
    logic [`MDATA_W-1:0]   wdata;
    logic [2:0]            byteCnt;
  } mem_req_t;

  typedef struct packed {
    logic                  wide32;
    logic [1:0]            byteSel;
  } mode_cfg_t;
endpackage : pio_pkg

// ---- verification/ext_memory_model.sv ----
`include "pio_consts.svh"
module ext_memory_model (
  input wire logic [`ADDR_W-1:0]  memory_address_out, // address
  input wire logic                speed_area_select,  // area bit
  input wire logic                mem_wr_n,           // write
  input wire logic                mem_rd_n,           // read
  input wire logic                slaveMode,          // 1: byte memory
  input wire logic [`MDATA_W-1:0] wrData,             // bus level
  output logic     [`MDATA_W-1:0] rdData              // read drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`MDATA_W-1:0] mem32 [0:8191];
  logic [`SDATA_W-1:0] mem8 [0:8191];
  logic [`MDATA_W-1:0] last = 32'h0;
  logic [`AREG_W-1:0]  a;
  assign a = {speed_area_select, memory_address_out};
  // store while address and data are held valid
  always @(negedge mem_wr_n) begin
    if (slaveMode) mem8[a] = wrData[7:0];
    else mem32[a] = wrData;
  end
  always @(negedge mem_rd_n) last = slaveMode ? {24'h0, mem8[a]} : mem32[a];
  // released bus shows the inverse of the last value
  assign rdData = !mem_rd_n ? (slaveMode ? {24'h0, mem8[a]} : mem32[a]) : ~last;
endmodule : ext_memory_model

// ---- verification/pio_port_properties.sv ----
`include "pio_consts.svh"
module pio_port_checker
  import pio_pkg::*;
(
  input wire logic                clk_sys,               // clock
  input wire logic                srst,                  // reset
  input wire logic                slaveMode,             // mode pin
  input wire mem_req_t            memReq,                // request
  input wire logic                memBusy,               // busy
  input wire logic                memRdValid,            // read done
  input wire logic                sysClkOut,             // half clock
  input wire logic                gpoWrEn,               // gp write
  input wire logic [`GP_W-1:0]    gpoWrData,             // gp data
  input wire logic [`GP_W-1:0]    gp_output_pins,        // gp outputs
  input wire logic                host_cs_n,             // select
  input wire logic                host_read_strobe_n,    // host read
  input wire logic                host_data_bus_oe,      // host drive
  input wire logic [`ADDR_W-1:0]  memory_address_out,    // address
  input wire logic                speed_area_select,     // area bit
  input wire logic                mem_wr_n,              // write
  input wire logic                mem_rd_n,              // read
  input wire logic                master_memory_data_oe, // wide drive
  input wire logic                slave_memory_data_oe   // byte drive
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic taken;
  assign taken = memReq.valid && !memBusy && sysClkOut;
  host_release_a: assert property (
    (host_cs_n || host_read_strobe_n) [*8] |-> !host_data_bus_oe)
    else $error("host bus driven while not read");
  host_drive_a: assert property (
    (slaveMode && !host_cs_n && !host_read_strobe_n) [*8] |-> host_data_bus_oe)
    else $error("host bus not driven during read");
  strobe_excl_a: assert property (mem_rd_n || mem_wr_n)
    else $error("read and write low together");
  bus_release_a: assert property (
    (slave_memory_data_oe || master_memory_data_oe) |-> mem_rd_n)
    else $error("memory bus driven during read");
  write_data_a: assert property (
    !mem_wr_n |-> (slaveMode ? slave_memory_data_oe : master_memory_data_oe))
    else $error("write strobe without data drive");
  half_clock_a: assert property (!$past(srst) |-> sysClkOut != $past(sysClkOut))
    else $error("system clock not toggling");
  gp_hold_a: assert property (!$past(srst) |-> gp_output_pins ==
    ($past(gpoWrEn) ? $past(gpoWrData) : $past(gp_output_pins)))
    else $error("general outputs wrong");
  fetch_addr_a: assert property (taken && memReq.isFetch |=>
    !speed_area_select && memory_address_out == $past(memReq.addr[11:0]))
    else $error("fetch address wrong");
  data_addr_a: assert property (taken && !memReq.isFetch |=>
    {speed_area_select, memory_address_out} == $past(memReq.addr))
    else $error("data address wrong");
  read_done_a: assert property (taken && !memReq.write |-> ##[4:40] memRdValid)
    else $error("read never completed");
  cover property (memRdValid);
  cover property (host_data_bus_oe);
  cover property (!mem_wr_n && slave_memory_data_oe);
endmodule : pio_port_checker

bind dsp_parallel_port pio_port_checker pio_port_checker_i (.clk_sys, .srst, .slaveMode,
  .memReq, .memBusy, .memRdValid, .sysClkOut, .gpoWrEn, .gpoWrData, .gp_output_pins,
  .host_cs_n, .host_read_strobe_n, .host_data_bus_oe, .memory_address_out,
  .speed_area_select, .mem_wr_n, .mem_rd_n, .master_memory_data_oe, .slave_memory_data_oe);

// ---- verification/testbench.sv ----
`include "pio_consts.svh"
module testbench
  import pio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic wr, fe;
    logic [12:0] a;
    logic [31:0] d;
    logic [2:0] n;
    logic [1:0] sel;
    logic [31:0] m;
  } row_t;
  logic clk_sys = 1'h0, srst = 1'h1, slaveMode = 1'h0, gpoWrEn = 1'h0;
  logic hostTxLoad = 1'h0, hostRxTake = 1'h0, host_cs_n = 1'h1;
  logic host_write_strobe_n = 1'h1, host_read_strobe_n = 1'h1;
  mem_req_t memReq = '0;
  mode_cfg_t modeCfg = '0;
  logic [1:0] gpoWrData = 2'h0, gp_input_pins = 2'h1, gpInRead, gp_output_pins;
  logic [31:0] hostTxWord = 32'h0, q, memRdData, hostRxWord, rdData;
  logic [31:0] master_memory_data_i, master_memory_data_o;
  logic [15:0] hostVal = 16'h0, h, host_data_bus_i, host_data_bus_o;
  logic memBusy, memRdValid, hostRxValid, sysClkOut, host_data_bus_oe;
  logic host_transfer_request, speed_area_select, mem_wr_n, mem_rd_n;
  logic master_memory_data_oe, slave_memory_data_oe;
  logic [11:0] memory_address_out;
  logic [7:0] slave_memory_data_i, slave_memory_data_o;
  int fail_count = 0, checked = 0, cyc = 0;
  row_t rows [13] = '{
    '{1'h1, 1'h0, 13'h0123, 32'h89ab_cdef, 3'h0, 2'h0, 32'h0},
    '{1'h1, 1'h0, 13'h1123, 32'h0246_8ace, 3'h0, 2'h0, 32'h0},
    '{1'h0, 1'h0, 13'h0123, 32'h89ab_cdef, 3'h0, 2'h0, 32'hffff_ffff},
    '{1'h0, 1'h0, 13'h1123, 32'h0246_8ace, 3'h0, 2'h0, 32'hffff_ffff},
    '{1'h0, 1'h1, 13'h1123, 32'h89ab_cdef, 3'h0, 2'h0, 32'hffff_ffff},
    '{1'h1, 1'h0, 13'h0040, 32'ha1b2_c3d4, 3'h4, 2'h0, 32'h0},
    '{1'h0, 1'h0, 13'h0040, 32'ha1b2_c3d4, 3'h4, 2'h0, 32'hffff_ffff},
    '{1'h0, 1'h0, 13'h0042, 32'h0000_00b2, 3'h1, 2'h0, 32'h0000_00ff},
    '{1'h1, 1'h0, 13'h1041, 32'h0000_5566, 3'h2, 2'h0, 32'h0},
    '{1'h0, 1'h0, 13'h1041, 32'h0000_5566, 3'h2, 2'h0, 32'h0000_ffff},
    '{1'h1, 1'h0, 13'h0050, 32'h0077_8899, 3'h0, 2'h2, 32'h0},
    '{1'h0, 1'h0, 13'h0050, 32'h0077_8899, 3'h0, 2'h2, 32'h00ff_ffff},
    '{1'h0, 1'h0, 13'h0041, 32'h00a1_b2c3, 3'h3, 2'h0, 32'h00ff_ffff}};
  assign host_data_bus_i = host_data_bus_oe ? host_data_bus_o : hostVal;
  assign master_memory_data_i = master_memory_data_oe ? master_memory_data_o : rdData;
  assign slave_memory_data_i = slave_memory_data_oe ? slave_memory_data_o : rdData[7:0];
  dsp_parallel_port dsp_parallel_port_i (.clk_sys, .srst, .slaveMode, .memReq, .modeCfg,
    .gpoWrData, .gpoWrEn, .hostTxWord, .hostTxLoad, .hostRxTake, .memBusy, .memRdData,
    .memRdValid, .hostRxWord, .hostRxValid, .gpInRead, .sysClkOut, .host_cs_n,
    .host_write_strobe_n, .host_read_strobe_n, .host_data_bus_i, .host_data_bus_o,
    .host_data_bus_oe, .host_transfer_request, .memory_address_out, .speed_area_select,
    .mem_wr_n, .mem_rd_n, .master_memory_data_i, .master_memory_data_o,
    .master_memory_data_oe, .slave_memory_data_i, .slave_memory_data_o,
    .slave_memory_data_oe, .gp_input_pins, .gp_output_pins);
  ext_memory_model ext_memory_model_i (.memory_address_out, .speed_area_select, .mem_wr_n,
    .mem_rd_n, .slaveMode, .rdData,
    .wrData(slaveMode ? {24'h0, slave_memory_data_i} : master_memory_data_i));
  // ****
  // helpers
  // ****
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic mem_op(input mem_req_t r, output logic [31:0] d);
    int t;
    t = 0;
    d = 'x;
    memReq = r;
    do tick(1); while (memBusy !== 1'b1 && ++t < 60);
    memReq.valid = 1'b0;
    do begin
      tick(1);
      if (memRdValid === 1'b1) d = memRdData;
    end while (memBusy !== 1'b0 && ++t < 120);
  endtask : mem_op
  task automatic host_wr(input logic [15:0] v, input logic csn);
    host_cs_n = csn;
    hostVal = v;
    host_write_strobe_n = 1'b0;
    tick(5);
    host_write_strobe_n = 1'b1;
    tick(5);
    host_cs_n = 1'b1;
    hostVal = ~v;
    tick(4);
  endtask : host_wr
  task automatic host_rd(output logic [15:0] v);
    host_cs_n = 1'b0;
    host_read_strobe_n = 1'b0;
    tick(8);
    v = host_data_bus_i;
    host_read_strobe_n = 1'b1;
    tick(4);
    host_cs_n = 1'b1;
    tick(4);
  endtask : host_rd
  task automatic do_reset(input logic mode);
    srst = 1'b1;
    tick(2);
    chk({mem_wr_n, mem_rd_n, host_data_bus_oe} === 3'h6, "reset strobes");
    chk({host_transfer_request, gp_output_pins} === 3'h0, "reset outputs");
    slaveMode = mode;
    tick(10);
    srst = 1'b0;
    tick(6);
  endtask : do_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // ****
  // tests
  // ****
  initial begin
    tick(12);
    srst = 1'b0;
    tick(6);
    foreach (rows[i]) begin
      if (i == 5) do_reset(1'b1);
      modeCfg.byteSel = rows[i].sel;
      mem_op({1'b1, rows[i].wr, rows[i].fe, rows[i].a, rows[i].d, rows[i].n}, q);
      if (!rows[i].wr) chk((q & rows[i].m) === rows[i].d, "memory read");
    end
    $display("test memory rows done");
    chk(host_transfer_request === 1'b1, "request idle");
    host_wr(16'h3c5a, 1'b0);
    chk(hostRxValid === 1'b1 && hostRxWord[15:0] === 16'h3c5a, "host word");
    chk(host_transfer_request === 1'b0, "request while full");
    pulse(hostRxTake);
    host_wr(16'h1111, 1'b1);
    chk(hostRxValid === 1'b0, "deselected write taken");
    modeCfg.wide32 = 1'b1;
    host_wr(16'h5678, 1'b0);
    host_wr(16'h1234, 1'b0);
    chk(hostRxWord === 32'h1234_5678, "host wide word");
    pulse(hostRxTake);
    hostTxWord = 32'h1357_9bdf;
    pulse(hostTxLoad);
    chk(host_transfer_request === 1'b1, "request for read");
    host_rd(h);
    chk(h === 16'h9bdf, "host low half");
    host_rd(h);
    chk(h === 16'h1357, "host high half");
    $display("test host port done");
    gp_input_pins = 2'h2;
    tick(4);
    chk(gpInRead === 2'h2, "general inputs");
    gpoWrData = 2'h3;
    pulse(gpoWrEn);
    gpoWrData = 2'h0;
    tick(6);
    chk(gp_output_pins === 2'h3, "general outputs");
    do_reset(1'b1);
    $display("test pins and reset done");
    finish_test();
  end
endmodule : testbench
